// [rtl/can_mode_consts.svh]
`ifndef CAN_MODE_CONSTS_SVH
`define CAN_MODE_CONSTS_SVH

// register word offsets, taken from haddr bits 4:2
`define OFS_CTRL_ONE    3'h0
`define OFS_CTRL_TWO    3'h1
`define OFS_INT_CODE    3'h2
`define OFS_AREA_CTRL   3'h3
`define OFS_AREA_STAT   3'h4
`define OFS_LAST        3'h4

// control one field positions
`define C1_STOP_BIT     13
`define C1_ABORT_BIT    12
`define C1_REQ_MSB      10
`define C1_REQ_LSB      8
`define C1_CAP_BIT      3
`define C1_WIN_BIT      0

// control two / area control field positions
`define C2_FBC_MSB      4
`define C2_FBC_LSB      0
`define AC_BCS_MSB      15
`define AC_BCS_LSB      13
`define AC_FSA_MSB      4
`define AC_FSA_LSB      0

// reset values and limits
`define REQ_RESET       3'h4
`define FBC_MAX         5'h11
`define BCS_RESERVED    3'h7
`define IDLE_BITS       4'hb

// interrupt codes
`define IC_NONE         7'h40
`define IC_ERROR        7'h41
`define IC_WAKE         7'h42
`define IC_OVERFLOW     7'h43
`define IC_ALMOST_FULL  7'h44

`endif

// [rtl/can_mode_pkg.sv]
package can_mode_pkg;

	typedef enum logic [2:0] {
		mode_normal  = 3'b000,
		mode_disable = 3'b001,
		mode_loop    = 3'b010,
		mode_listen  = 3'b011,
		mode_config  = 3'b100,
		mode_all     = 3'b111
	} mode_t;

	// events from the protocol engine, same clock
	typedef struct packed {
		logic       bit_tick;
		logic       tx_active;
		logic       tx_internal;
		logic       rx_msg_done;
		logic       rx_error;
		logic       rx_store;
		logic       sw_read_done;
		logic       abort_done;
		logic [4:0] filter_hit;
		logic       evt_error;
		logic       evt_wake;
		logic       evt_overflow;
		logic       evt_almost_full;
		logic       buf_evt;
		logic [3:0] buf_num;
	} engine_in_t;

	// controls toward engine and pins
	typedef struct packed {
		logic tx_out;
		logic tx_oe;
		logic rx_owned;
		logic engine_rx;
		logic err_cnt_en;
		logic active_en;
		logic module_run;
		logic capture_event;
		logic abort_req;
		logic window_sel;
		logic copy_on_error;
	} engine_out_t;

	typedef struct packed {
		logic [2:0]  req_mode;
		mode_t       cur_mode;
		logic        stop_idle;
		logic        abort;
		logic        cap_en;
		logic        register_window_select;
		logic [4:0]  fbc;
		logic [4:0]  filt;
		logic [6:0]  icode;
		logic [2:0]  bcs;
		logic [4:0]  fsa;
		logic [5:0]  wptr;
		logic [5:0]  rptr;
		logic        rx_m;
		logic        rx_s;
		logic [3:0]  idle_cnt;
		logic        wr_pend;
		logic [2:0]  wr_idx;
		logic [31:0] hrdata;
		logic        ready;
		engine_out_t eo;
	} state_t;

endpackage

// [rtl/can_mode_fifo_control.sv]
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "can_mode_consts.svh"
module can_mode_fifo_control (
	// clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// ahb-lite slave
	input  wire logic                       hsel,
	input  wire logic [7:0]                 haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic                       hready,
	input  wire logic [31:0]                hwdata,
	output logic      [31:0]                hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	// protocol engine and processor state
	input  wire can_mode_pkg::engine_in_t   eng,
	input  wire logic                       cpu_idle,
	// bus pins and engine controls
	input  wire logic                       bus_rx_pin,
	output can_mode_pkg::engine_out_t       ctl
);
	import can_mode_pkg::*;

	state_t r;
	state_t n;

	// buffers held in memory for a buffer count code
	function automatic logic [5:0] buf_total(input logic [2:0] c);
		logic [5:0] t;
		t = 6'h04;
		unique case (c)
			3'h0: t = 6'h04;
			3'h1: t = 6'h06;
			3'h2: t = 6'h08;
			3'h3: t = 6'h0c;
			3'h4: t = 6'h10;
			3'h5: t = 6'h18;
			3'h6: t = 6'h20;
			3'h7: t = 6'h20;
		endcase
		return t;
	endfunction

	// area pointer step with wrap back to the area start
	function automatic logic [5:0] step(input logic [5:0] p,
	                                    input logic [2:0] c,
	                                    input logic [4:0] s);
		logic [5:0] last;
		last = buf_total(c) - 6'h01;
		return (p >= last) ? {1'b0, s} : p + 6'h01;
	endfunction

	logic       addr_ok;
	logic       rd_take;
	logic       wr_take;
	logic       req_ok;
	logic       off_bus;
	logic       bus_idle;
	logic       in_cfg;
	logic       halted;
	logic       store;
	logic [2:0] idx;
	logic [2:0] wreq;
	logic [4:0] wfbc;
	logic [2:0] wbcs;

	assign idx     = haddr[4:2];
	assign addr_ok = (haddr[7:5] == 3'h0) && (idx <= `OFS_LAST);
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	assign wr_take = hsel && hready && htrans[1] && hwrite;
	assign in_cfg  = (r.cur_mode == mode_config);
	assign halted  = r.stop_idle && cpu_idle;
	assign wreq    = hwdata[`C1_REQ_MSB:`C1_REQ_LSB];
	assign wfbc    = hwdata[`C2_FBC_MSB:`C2_FBC_LSB];
	assign wbcs    = hwdata[`AC_BCS_MSB:`AC_BCS_LSB];

	// 101 and 110 never become a mode
	assign req_ok  = (r.req_mode != 3'h5) && (r.req_mode != 3'h6);
	// off-bus modes see no frames, so a change needs no idle gap
	assign off_bus = (r.cur_mode == mode_config) ||
	                 (r.cur_mode == mode_disable) ||
	                 (r.cur_mode == mode_loop);
	assign bus_idle = (r.idle_cnt >= `IDLE_BITS);
	// listen-all keeps what was assembled up to an error
	assign store = eng.rx_store ||
	               (r.cur_mode == mode_all && eng.rx_error);

	// next state
	always_comb begin
		n = r;
		n.ready = 1'b1;
		// pin synchroniser, first stage read only here
		n.rx_m = bus_rx_pin;
		n.rx_s = r.rx_m;

		// consecutive recessive bit count, saturating
		if (eng.bit_tick && !halted) begin
			if (!r.rx_s)
				n.idle_cnt = 4'h0;
			else if (r.idle_cnt < `IDLE_BITS)
				n.idle_cnt = r.idle_cnt + 4'h1;
		end

		// mode change only at bus idle or from an off-bus mode; config waits for tx to end
		if (req_ok && !halted && (r.req_mode != r.cur_mode) &&
		    (bus_idle || off_bus) &&
		    !(r.req_mode == mode_config && eng.tx_active)) begin
			n.cur_mode = mode_t'(r.req_mode);
		end

		// hardware clears abort; a new software set wins below
		if (eng.abort_done)
			n.abort = 1'b0;

		// latch matched filter per received message
		if (eng.rx_msg_done)
			n.filt = eng.filter_hit;

		// interrupt code by fixed priority
		if (eng.evt_error)
			n.icode = `IC_ERROR;
		else if (eng.evt_wake)
			n.icode = `IC_WAKE;
		else if (eng.evt_overflow)
			n.icode = `IC_OVERFLOW;
		else if (eng.evt_almost_full)
			n.icode = `IC_ALMOST_FULL;
		else if (eng.buf_evt)
			n.icode = {3'h0, eng.buf_num};
		else
			n.icode = `IC_NONE;

		// receive area pointers
		if (store)
			n.wptr = step(r.wptr, r.bcs, r.fsa);
		if (eng.sw_read_done)
			n.rptr = step(r.rptr, r.bcs, r.fsa);

		// ahb data phase write
		n.wr_pend = wr_take && addr_ok;
		n.wr_idx  = idx;
		if (r.wr_pend) begin
			unique case (r.wr_idx)
				`OFS_CTRL_ONE: begin
					n.req_mode = wreq;
					if (hwdata[`C1_ABORT_BIT])
						n.abort = 1'b1;
					// remaining control bits locked outside config
					if (in_cfg) begin
						n.stop_idle = hwdata[`C1_STOP_BIT];
						n.cap_en    = hwdata[`C1_CAP_BIT];
						n.register_window_select       = hwdata[`C1_WIN_BIT];
					end
				end
				`OFS_CTRL_TWO: begin
					if (in_cfg && wfbc <= `FBC_MAX)
						n.fbc = wfbc;
				end
				`OFS_AREA_CTRL: begin
					if (in_cfg) begin
						if (wbcs != `BCS_RESERVED)
							n.bcs = wbcs;
						n.fsa  = hwdata[`AC_FSA_MSB:`AC_FSA_LSB];
						n.wptr = {1'b0, hwdata[`AC_FSA_MSB:`AC_FSA_LSB]};
						n.rptr = {1'b0, hwdata[`AC_FSA_MSB:`AC_FSA_LSB]};
					end
				end
				default: begin
				end
			endcase
		end

		// read data registered in the address phase
		if (rd_take) begin
			n.hrdata = 32'h0;
			if (addr_ok) begin
				unique case (idx)
					`OFS_CTRL_ONE:
						n.hrdata = {18'h0, r.stop_idle, r.abort, 1'b0,
						            r.req_mode, r.cur_mode, 1'b0,
						            r.cap_en, 2'h0, r.register_window_select};
					`OFS_CTRL_TWO:  n.hrdata = {27'h0, r.fbc};
					`OFS_INT_CODE:
						n.hrdata = {19'h0, r.filt, 1'b0, r.icode};
					`OFS_AREA_CTRL:
						n.hrdata = {16'h0, r.bcs, 8'h0, r.fsa};
					`OFS_AREA_STAT:
						n.hrdata = {18'h0, r.wptr, 2'h0, r.rptr};
					default: n.hrdata = 32'h0;
				endcase
			end
		end

		// pin ownership and engine enables per mode in force
		n.eo.tx_out      = 1'b1;
		n.eo.tx_oe       = 1'b0;
		n.eo.rx_owned    = 1'b0;
		n.eo.err_cnt_en  = 1'b0;
		n.eo.active_en   = 1'b0;
		n.eo.engine_rx   = r.rx_s;
		unique case (r.cur_mode)
			mode_normal: begin
				n.eo.tx_out     = r.eo.module_run ? eng.tx_internal : 1'b1;
				n.eo.tx_oe      = 1'b1;
				n.eo.rx_owned   = 1'b1;
				n.eo.err_cnt_en = 1'b1;
				n.eo.active_en  = 1'b1;
			end
			mode_listen: begin
				n.eo.rx_owned = 1'b1;
			end
			mode_all: begin
				n.eo.rx_owned = 1'b1;
			end
			mode_loop: begin
				n.eo.engine_rx = eng.tx_internal;
			end
			mode_disable, mode_config: begin
				n.eo.engine_rx = 1'b1;
			end
		endcase
		n.eo.module_run    = !halted;
		n.eo.capture_event = r.cap_en && eng.rx_msg_done;
		n.eo.abort_req     = n.abort;
		n.eo.window_sel    = n.register_window_select;
		n.eo.copy_on_error = (r.cur_mode == mode_all);
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r           <= '0;
			r.req_mode  <= `REQ_RESET;
			r.cur_mode  <= mode_config;
			r.icode     <= `IC_NONE;
			r.rx_m      <= 1'b1;
			r.rx_s      <= 1'b1;
			r.eo.tx_out <= 1'b1;
			r.eo.engine_rx <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign hrdata    = r.hrdata;
	assign hreadyout = r.ready;
	assign hresp     = 1'b0;
	assign ctl       = r.eo;

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_res_keep;
		(r.req_mode == 3'h5 || r.req_mode == 3'h6) |=>
			$stable(r.cur_mode);
	endproperty
	a_res_keep: assert property (p_res_keep)
		else $error("reserved request changed mode");

	property p_idle_wait;
		$changed(r.cur_mode) |->
			($past(r.idle_cnt) >= `IDLE_BITS) ||
			$past(r.cur_mode == mode_config ||
			      r.cur_mode == mode_disable ||
			      r.cur_mode == mode_loop);
	endproperty
	a_idle_wait: assert property (p_idle_wait)
		else $error("mode changed without bus idle");

	property p_listen_pins;
		r.cur_mode == mode_listen |=>
			!ctl.tx_oe && ctl.rx_owned && !ctl.active_en &&
			!ctl.err_cnt_en;
	endproperty
	a_listen_pins: assert property (p_listen_pins)
		else $error("listen-only pin use wrong");

	// normal mode owns both pins and runs the error counters
	property p_normal_pins;
		r.cur_mode == mode_normal |=>
			ctl.tx_oe && ctl.rx_owned && ctl.active_en && ctl.err_cnt_en;
	endproperty
	a_normal_pins: assert property (p_normal_pins)
		else $error("normal mode pin use wrong");

	property p_loop;
		r.cur_mode == mode_loop |=>
			ctl.engine_rx == $past(eng.tx_internal) &&
			!ctl.tx_oe && !ctl.rx_owned;
	endproperty
	a_loop: assert property (p_loop)
		else $error("loopback path wrong");

	property p_capture;
		eng.rx_msg_done ##0 r.cap_en |=> ctl.capture_event;
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture pulse missing");

	property p_no_capture;
		!r.cap_en |=> !ctl.capture_event;
	endproperty
	a_no_capture: assert property (p_no_capture)
		else $error("capture while disabled");

	property p_abort_set;
		r.wr_pend && r.wr_idx == `OFS_CTRL_ONE &&
		hwdata[`C1_ABORT_BIT] |=> ctl.abort_req;
	endproperty
	a_abort_set: assert property (p_abort_set)
		else $error("abort request lost");

	// finished aborts drop the request unless software sets it again
	property p_abort_clear;
		eng.abort_done &&
		!(r.wr_pend && r.wr_idx == `OFS_CTRL_ONE && hwdata[`C1_ABORT_BIT])
			|=> !ctl.abort_req;
	endproperty
	a_abort_clear: assert property (p_abort_clear)
		else $error("abort request not cleared");

	property p_icode_none;
		!(eng.evt_error || eng.evt_wake || eng.evt_overflow ||
		  eng.evt_almost_full || eng.buf_evt) |=> r.icode == `IC_NONE;
	endproperty
	a_icode_none: assert property (p_icode_none)
		else $error("idle interrupt code wrong");

	property p_cfg_lock;
		r.cur_mode != mode_config |=> $stable(r.bcs) && $stable(r.fsa);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock)
		else $error("area control changed outside config");

	property p_ptr_range;
		r.wptr <= 6'h1f && r.rptr <= 6'h1f;
	endproperty
	a_ptr_range: assert property (p_ptr_range)
		else $error("area pointer out of range");

	c_normal: cover property (r.cur_mode == mode_normal);
	c_loop:   cover property (r.cur_mode == mode_loop);
	c_all_err: cover property (r.cur_mode == mode_all && eng.rx_error);
	c_wrap:   cover property (store ##1 r.wptr == {1'b0, r.fsa});

endmodule
`default_nettype wire

// [sim/can_bus_node.sv]
`timescale 1ns/1ps
`default_nettype none
// transceiver plus other nodes: wired-and bus, pull-up makes it recessive
module can_bus_node (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// node side
	input  wire logic tx_out,
	input  wire logic tx_oe,
	input  wire logic busy,
	// bus side
	output logic      bus_rx_pin,
	output logic      bit_tick
);
	logic [1:0] div;
	// other traffic holds the bus dominant, so no idle can be seen
	assign bus_rx_pin = !busy && (!tx_oe || tx_out);
	// one bit time per four clocks keeps idle waits short
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= 2'h0;
		end else begin
			div <= div + 2'h1;
		end
	end
	assign bit_tick = (div == 2'h3);
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import can_mode_pkg::*;
	localparam logic [7:0] A_C1 = 8'h00, A_C2 = 8'h04, A_IC = 8'h08;
	localparam logic [7:0] A_AC = 8'h0c, A_AS = 8'h10, A_BAD = 8'h20;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        cpu_idle, busy, tick, rx_pin;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata;
	engine_in_t  eng_tb, eng;
	engine_out_t ctl;
	int          err_total, total_checks, cycles;
	// bit timing comes from the bus model, the rest from the scenarios
	always_comb begin
		eng = eng_tb;
		eng.bit_tick = tick;
	end
	can_mode_fifo_control i_can_mode_fifo_control (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .eng(eng), .cpu_idle(cpu_idle),
		.bus_rx_pin(rx_pin), .ctl(ctl));
	can_bus_node i_can_bus_node (.hclk(hclk), .hresetn(hresetn),
		.tx_out(ctl.tx_out), .tx_oe(ctl.tx_oe), .busy(busy),
		.bus_rx_pin(rx_pin), .bit_tick(tick));
	always #5 hclk = ~hclk;
	task automatic final_report();
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// hang guard, well above the expected run length
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			final_report();
		end
	end
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	// one single ahb-lite transfer, address phase held until hready
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'b010;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// idle cycle after a write, a read right behind it sees new data
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		xfer(a, 1'b1, d, rd);
		@(posedge hclk);
	endtask
	task automatic rdchk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] rd;
		xfer(a, 1'b0, 32'h0, rd);
		chk(n, e, rd);
	endtask
	task automatic mode_to(input logic [2:0] m);
		logic [31:0] rd;
		wr(A_C1, {21'h0, m, 8'h0});
		// start from a field value that can never match, so one read happens
		rd = {24'h0, ~m, 5'h0};
		for (int i = 0; i < 60 && rd[7:5] !== m; i++) begin
			xfer(A_C1, 1'b0, 32'h0, rd);
		end
		chk("current_mode", {29'h0, m}, {29'h0, rd[7:5]});
		repeat (3) @(posedge hclk);
	endtask
	// the capture pulse stands only in the cycle after the message edge
	task automatic cap_seen(output logic s);
		s = 1'b0;
		eng_tb.rx_msg_done <= 1'b1;
		@(posedge hclk);
		eng_tb.rx_msg_done <= 1'b0;
		repeat (3) begin
			#1 if (ctl.capture_event === 1'b1) s = 1'b1;
			@(posedge hclk);
		end
	endtask
	task automatic t_reset();
		rdchk("ctrl_one", A_C1, 32'h0480);
		chk("hresp", 32'h0, 32'(hresp));
		rdchk("int_code", A_IC, 32'h0040);
		rdchk("unmapped", A_BAD, 32'h0);
	endtask
	task automatic t_area();
		wr(A_AC, 32'h4004);
		rdchk("area_ctrl", A_AC, 32'h4004);
		rdchk("area_stat", A_AS, 32'h0404);
		wr(A_AC, 32'he004);
		rdchk("area_ctrl", A_AC, 32'h4004);
		repeat (3) begin
			eng_tb.rx_store <= 1'b1;
			@(posedge hclk);
			eng_tb.rx_store <= 1'b0;
			@(posedge hclk);
		end
		eng_tb.sw_read_done <= 1'b1;
		@(posedge hclk);
		eng_tb.sw_read_done <= 1'b0;
		@(posedge hclk);
		rdchk("area_stat", A_AS, 32'h0705);
		// eight buffers: the write pointer wraps from 7 to the start
		eng_tb.rx_store <= 1'b1;
		@(posedge hclk);
		eng_tb.rx_store <= 1'b0;
		@(posedge hclk);
		rdchk("area_stat", A_AS, 32'h0405);
		wr(A_C2, 32'h11);
		rdchk("filter_count", A_C2, 32'h11);
		wr(A_C2, 32'h12);
		rdchk("filter_count", A_C2, 32'h11);
	endtask
	task automatic t_icode();
		eng_tb.buf_evt <= 1'b1;
		eng_tb.buf_num <= 4'h5;
		eng_tb.filter_hit <= 5'h09;
		// the filter number is taken only with a finished message
		eng_tb.rx_msg_done <= 1'b1;
		@(posedge hclk);
		eng_tb.rx_msg_done <= 1'b0;
		// each event alone, then the buffer number shows through
		for (int i = 0; i < 4; i++) begin
			{eng_tb.evt_error, eng_tb.evt_wake, eng_tb.evt_overflow,
				eng_tb.evt_almost_full} <= 4'h8 >> i;
			repeat (3) @(posedge hclk);
			rdchk("int_code", A_IC, 32'h0941 + i);
		end
		eng_tb.evt_almost_full <= 1'b0;
		eng_tb.buf_num <= 4'hf;
		repeat (3) @(posedge hclk);
		rdchk("int_code", A_IC, 32'h090f);
		eng_tb.buf_evt <= 1'b0;
		repeat (3) @(posedge hclk);
		rdchk("int_code", A_IC, 32'h0940);
	endtask
	task automatic t_ctl();
		logic s;
		wr(A_C1, 32'h1409);
		chk("abort_req", 32'h1, 32'(ctl.abort_req));
		chk("window_sel", 32'h1, 32'(ctl.window_sel));
		rdchk("ctrl_one", A_C1, 32'h1489);
		cap_seen(s);
		chk("capture", 32'h1, 32'(s));
		eng_tb.abort_done <= 1'b1;
		@(posedge hclk);
		eng_tb.abort_done <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("abort_req", 32'h0, 32'(ctl.abort_req));
		rdchk("ctrl_one", A_C1, 32'h0489);
		wr(A_C1, 32'h0400);
		cap_seen(s);
		chk("capture", 32'h0, 32'(s));
		chk("window_sel", 32'h0, 32'(ctl.window_sel));
	endtask
	task automatic t_modes();
		mode_to(3'h0);
		chk("tx_oe", 32'h1, 32'(ctl.tx_oe));
		chk("rx_owned", 32'h1, 32'(ctl.rx_owned));
		chk("err_cnt_en", 32'h1, 32'(ctl.err_cnt_en));
		chk("active_en", 32'h1, 32'(ctl.active_en));
		eng_tb.tx_internal <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("tx_out", 32'h0, 32'(ctl.tx_out));
		eng_tb.tx_internal <= 1'b1;
		wr(A_C1, 32'h2008);
		rdchk("ctrl_one", A_C1, 32'h0000);
		// on the bus, filter count and area control are locked
		wr(A_C2, 32'h05);
		rdchk("filter_count", A_C2, 32'h11);
		wr(A_AC, 32'h0008);
		rdchk("area_ctrl", A_AC, 32'h4004);
		cpu_idle <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("module_run", 32'h1, 32'(ctl.module_run));
		cpu_idle <= 1'b0;
		// a busy bus must hold the mode back
		busy <= 1'b1;
		wr(A_C1, 32'h0200);
		repeat (100) @(posedge hclk);
		rdchk("ctrl_one", A_C1, 32'h0200);
		busy <= 1'b0;
		mode_to(3'h2);
		chk("tx_oe", 32'h0, 32'(ctl.tx_oe));
		chk("rx_owned", 32'h0, 32'(ctl.rx_owned));
		eng_tb.tx_internal <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("engine_rx", 32'h0, 32'(ctl.engine_rx));
		eng_tb.tx_internal <= 1'b1;
		mode_to(3'h3);
		chk("tx_oe", 32'h0, 32'(ctl.tx_oe));
		chk("rx_owned", 32'h1, 32'(ctl.rx_owned));
		chk("err_cnt_en", 32'h0, 32'(ctl.err_cnt_en));
		chk("active_en", 32'h0, 32'(ctl.active_en));
		wr(A_C1, 32'h0500);
		repeat (80) @(posedge hclk);
		rdchk("ctrl_one", A_C1, 32'h0560);
		mode_to(3'h7);
		chk("copy_on_error", 32'h1, 32'(ctl.copy_on_error));
		chk("active_en", 32'h0, 32'(ctl.active_en));
		// an error in listen-all still stores the partial message
		eng_tb.rx_error <= 1'b1;
		@(posedge hclk);
		eng_tb.rx_error <= 1'b0;
		@(posedge hclk);
		rdchk("area_stat", A_AS, 32'h0505);
		mode_to(3'h1);
		mode_to(3'h4);
		wr(A_C1, 32'h2400);
		cpu_idle <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("module_run", 32'h0, 32'(ctl.module_run));
		cpu_idle <= 1'b0;
	endtask
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hsize = 3'b010;
		hwdata = 32'h0;
		cpu_idle = 1'b0;
		busy = 1'b0;
		eng_tb = '0;
		eng_tb.tx_internal = 1'b1;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_area();
		t_icode();
		t_ctl();
		t_modes();
		final_report();
	end
endmodule
`default_nettype wire
